// ---- logic/thermal_cfg_pkg.sv ----
// Purpose: constants and helpers shared by the configuration register bank
// Assumes: 8-bit registers reached through an 8-bit address pointer
// Notes: temperatures arrive as signed whole degrees from the converter
package thermal_cfg_pkg;

   // pointer values of the registers held or served here
   localparam logic [7:0] PTR_LOCAL_HI = 8'h00;
   localparam logic [7:0] PTR_R1_HI = 8'h01;
   localparam logic [7:0] PTR_PRIMARY_RD = 8'h03;
   localparam logic [7:0] PTR_PRIMARY_WR = 8'h09;
   localparam logic [7:0] PTR_R1_LO = 8'h10;
   localparam logic [7:0] PTR_LOCK_CFG = 8'h24;
   localparam logic [7:0] PTR_R2_HI = 8'h30;
   localparam logic [7:0] PTR_R2_LO = 8'h33;

   // primary_configuration field positions
   localparam int ALERT_MASK_BIT = 7;
   localparam int STANDBY_BIT = 6;
   localparam int PIN_ROLE_BIT = 5;
   localparam int REMOTE_VIEW_BIT = 3;
   localparam int RANGE_BIT = 2;
   localparam int R1_SUPPRESS_BIT = 1;
   localparam int R2_SUPPRESS_BIT = 0;
   // lock_configuration field position
   localparam int LOCK_BIT = 7;

   // writable bits; bit 4 and lock bits 6..0 are reserved
   localparam logic [7:0] PRIMARY_WR_MASK = 8'hEF;
   localparam logic [7:0] UNLOCKED_ONLY_MASK = 8'h08;

   // reset values
   localparam logic [7:0] PRIMARY_RESET = 8'h00;
   localparam logic [7:0] LOCK_CFG_RESET = 8'h00;
   localparam logic [7:0] RESULT_RESET = 8'h00;

   // data format figures
   localparam logic signed [9:0] EXT_OFFSET = 10'sh040;
   localparam logic signed [9:0] DEFAULT_MAX = 10'sh07F;
   localparam logic signed [9:0] EXT_MAX = 10'sh0FF;

   // whole degrees to the reported high byte in the selected range
   function automatic logic [7:0] format_high(
      input logic signed [9:0] degrees,
      input logic extended);
      logic signed [10:0] shifted;
      logic signed [9:0] top;
      // one spare bit so the +64 offset cannot wrap near full scale
      shifted = extended ? 11'(degrees) + 11'(EXT_OFFSET) : 11'(degrees);
      top = extended ? EXT_MAX : DEFAULT_MAX;
      if (shifted < 11'sh000) begin
         format_high = 8'h00;
      end else if (shifted > 11'(top)) begin
         format_high = top[7:0];
      end else begin
         format_high = shifted[7:0];
      end
   endfunction : format_high

   // quarter degrees sit in the two upper bits of the low byte
   function automatic logic [7:0] format_low(input logic [1:0] quarters);
      format_low = {quarters, 6'h00};
   endfunction : format_low

endpackage : thermal_cfg_pkg

// ---- logic/result_view_if.sv ----
// Purpose: carries captured result bytes from capture stage to read mux
// Assumes: single clock domain
// Notes: producer owns every byte
`timescale 1ns/1ns
interface result_view_if;
   logic [7:0] local_hi;
   logic [7:0] r1_hi;
   logic [7:0] r1_lo;
   logic [7:0] r2_hi;
   logic [7:0] r2_lo;

   modport producer (output local_hi, r1_hi, r1_lo, r2_hi, r2_lo);
   modport consumer (input local_hi, r1_hi, r1_lo, r2_hi, r2_lo);
endinterface : result_view_if

// ---- logic/result_capture.sv ----
// Purpose: latches conversion results in the format of the active range
// Assumes: conv_done is a one-cycle pulse on core_clk
// Notes: range is sampled at capture, so a range change shows at the next conversion
`timescale 1ns/1ns
module result_capture
   import thermal_cfg_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic conv_done,
   input wire logic extended,
   input wire logic signed [9:0] local_deg,
   input wire logic signed [9:0] r1_deg,
   input wire logic [1:0] r1_quarters,
   input wire logic signed [9:0] r2_deg,
   input wire logic [1:0] r2_quarters,
   result_view_if.producer view
);

   logic [7:0] local_hi;
   logic [7:0] r1_hi;
   logic [7:0] r1_lo;
   logic [7:0] r2_hi;
   logic [7:0] r2_lo;
   logic [7:0] next_local_hi;
   logic [7:0] next_r1_hi;
   logic [7:0] next_r1_lo;
   logic [7:0] next_r2_hi;
   logic [7:0] next_r2_lo;

   // new bytes only on a finished conversion; limits are never touched
   always_comb begin
      next_local_hi = local_hi;
      next_r1_hi = r1_hi;
      next_r1_lo = r1_lo;
      next_r2_hi = r2_hi;
      next_r2_lo = r2_lo;
      if (conv_done) begin // [R17]
         next_local_hi = format_high(local_deg, extended); // [R16]
         next_r1_hi = format_high(r1_deg, extended); // [R16]
         next_r1_lo = format_low(r1_quarters);
         next_r2_hi = format_high(r2_deg, extended); // [R16]
         next_r2_lo = format_low(r2_quarters);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         local_hi <= RESULT_RESET;
         r1_hi <= RESULT_RESET;
         r1_lo <= RESULT_RESET;
         r2_hi <= RESULT_RESET;
         r2_lo <= RESULT_RESET;
      end else begin
         local_hi <= next_local_hi;
         r1_hi <= next_r1_hi;
         r1_lo <= next_r1_lo;
         r2_hi <= next_r2_hi;
         r2_lo <= next_r2_lo;
      end
   end

   assign view.local_hi = local_hi;
   assign view.r1_hi = r1_hi;
   assign view.r1_lo = r1_lo;
   assign view.r2_hi = r2_hi;
   assign view.r2_lo = r2_lo;

endmodule : result_capture

// ---- logic/thermal_monitor_config_regs.sv ----
// Purpose: configuration and lock registers of a three-channel monitor
// Assumes: the serial engine presents pointer, write strobe and data on
//          core_clk; limit comparison runs outside and feeds level flags
// Notes: pins are open-drain, driven low when the matching _oe_n is low
//
// Function
// [R1] primary configuration read at pointer 0x03, written at 0x09, same bits.
// [R2] bit 7 set suppresses every alert output assertion; resets to 0.
// [R3] global alert mask acts only while shared pin is the alert output.
// [R4] bit 6 set enters standby, suspending conversions; resets to 0.
// [R5] in standby registers stay accessible and output pins stay live.
// [R6] limit writes in standby re-evaluate overtemp and alert outputs.
// [R7] bit 5 picks shared pin role: 0 alert, 1 second overtemp.
// [R8] bit 3 set shows second remote values at first remote locations.
// [R9] remote view select stays writable while lock is set.
// [R10] bit 2 picks range: 0 default 0..127, 1 extended.
// [R11] bit 1 set suppresses alerts from first remote channel.
// [R12] bit 0 set suppresses alerts from second remote channel.
// [R13] lock configuration at pointer 0x24; bits 6..0 reserved.
// [R14] writing 1 to lock bit 7 freezes lockable registers.
// [R15] lock cannot be cleared by writes; only power-on reset clears.
// [R16] extended range reports high bytes offset by +64, else binary.
// [R17] new format appears at next conversion; limits unchanged.
// [R18] with view select set, second remote high at 0x01, low 0x10.
// [R19] reserved bits read zero and ignore writes.
// [R20] primary bits except view select are lockable.
`timescale 1ns/1ns
module thermal_monitor_config_regs
   import thermal_cfg_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] reg_ptr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wr_data,
   output logic [7:0] reg_rd_data,
   input wire logic conv_done,
   input wire logic signed [9:0] local_deg,
   input wire logic signed [9:0] r1_deg,
   input wire logic [1:0] r1_quarters,
   input wire logic signed [9:0] r2_deg,
   input wire logic [1:0] r2_quarters,
   input wire logic local_out_of_limit,
   input wire logic r1_out_of_limit,
   input wire logic r2_out_of_limit,
   input wire logic overtemp_hit,
   input wire logic second_overtemp_hit,
   output logic conversions_suspended,
   output logic extended_range,
   output logic remote_view_second,
   output logic overtemp_out_n,
   output logic overtemp_oe_n,
   output logic shared_pin_out,
   output logic shared_pin_oe_n
);

   ////////////////////////////////////////////////////////////////////
   // configuration storage

   logic [7:0] primary_configuration;
   logic [7:0] lock_configuration;
   logic [7:0] next_primary;
   logic [7:0] next_lock;
   logic locked;
   logic [7:0] wr_allowed;

   assign locked = lock_configuration[LOCK_BIT];

   // view select is exempt from locking so a locked part stays readable
   always_comb begin
      wr_allowed = locked ? UNLOCKED_ONLY_MASK : PRIMARY_WR_MASK; // [R20]
      next_primary = primary_configuration;
      next_lock = lock_configuration;
      // writes are served in standby as well
      if (reg_wr && reg_ptr == PTR_PRIMARY_WR) begin // [R1] [R5]
         next_primary = (primary_configuration & ~wr_allowed)
                      | (reg_wr_data & wr_allowed); // [R9] [R19]
      end
      // lock only ever sets; a written 0 is ignored
      if (reg_wr && reg_ptr == PTR_LOCK_CFG && reg_wr_data[LOCK_BIT]) begin
         next_lock[LOCK_BIT] = 1'b1; // [R13] [R14] [R15]
      end
   end

   // only the power-on reset returns the lock to 0
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         primary_configuration <= PRIMARY_RESET;
         lock_configuration <= LOCK_CFG_RESET; // [R15]
      end else begin
         primary_configuration <= next_primary;
         lock_configuration <= next_lock;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // result capture in the active format

   result_view_if results ();

   result_capture u_capture (
      .core_clk(core_clk),
      .rst(rst),
      .conv_done(conv_done && !primary_configuration[STANDBY_BIT]), // [R4]
      .extended(primary_configuration[RANGE_BIT]), // [R10] [R16]
      .local_deg(local_deg),
      .r1_deg(r1_deg),
      .r1_quarters(r1_quarters),
      .r2_deg(r2_deg),
      .r2_quarters(r2_quarters),
      .view(results.producer)
   );

   ////////////////////////////////////////////////////////////////////
   // read data, one cycle after the pointer

   logic [7:0] next_rd_data;
   logic view_second;

   assign view_second = primary_configuration[REMOTE_VIEW_BIT];

   // unknown pointers read 0 here; the serial engine merges other banks
   always_comb begin
      next_rd_data = 8'h00;
      unique case (reg_ptr)
         PTR_PRIMARY_RD: next_rd_data = primary_configuration; // [R1]
         PTR_LOCK_CFG: next_rd_data = lock_configuration; // [R13] [R19]
         PTR_LOCAL_HI: next_rd_data = results.local_hi;
         PTR_R1_HI: next_rd_data = view_second ? results.r2_hi
                                               : results.r1_hi; // [R8] [R18]
         PTR_R1_LO: next_rd_data = view_second ? results.r2_lo
                                               : results.r1_lo; // [R8] [R18]
         PTR_R2_HI: next_rd_data = results.r2_hi;
         PTR_R2_LO: next_rd_data = results.r2_lo;
         default: next_rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rd_data <= 8'h00;
      end else begin
         reg_rd_data <= next_rd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin drive and control outputs

   logic alert_cause;
   logic alert_active;
   logic next_overtemp_oe_n;
   logic next_shared_oe_n;

   // limit flags are levels, so a limit rewritten in standby shows at once
   always_comb begin
      alert_cause = local_out_of_limit
         | (r1_out_of_limit & ~primary_configuration[R1_SUPPRESS_BIT]) // [R11]
         | (r2_out_of_limit & ~primary_configuration[R2_SUPPRESS_BIT]); // [R12]
      alert_active = alert_cause & ~primary_configuration[ALERT_MASK_BIT]; // [R2]
      next_overtemp_oe_n = ~overtemp_hit; // [R5] [R6]
      if (primary_configuration[PIN_ROLE_BIT]) begin // [R7]
         next_shared_oe_n = ~second_overtemp_hit; // [R3]
      end else begin
         next_shared_oe_n = ~alert_active; // [R3] [R6]
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         overtemp_oe_n <= 1'b1;
         shared_pin_oe_n <= 1'b1;
         conversions_suspended <= 1'b0;
         extended_range <= 1'b0;
         remote_view_second <= 1'b0;
      end else begin
         overtemp_oe_n <= next_overtemp_oe_n;
         shared_pin_oe_n <= next_shared_oe_n;
         conversions_suspended <= next_primary[STANDBY_BIT]; // [R4]
         extended_range <= next_primary[RANGE_BIT]; // [R10]
         remote_view_second <= next_primary[REMOTE_VIEW_BIT]; // [R8]
      end
   end

   // open-drain pins only ever pull low; level is held at 0 and the _oe_n enable decides the drive
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         overtemp_out_n <= 1'b0;
         shared_pin_out <= 1'b0;
      end else begin
         overtemp_out_n <= 1'b0;
         shared_pin_out <= 1'b0;
      end
   end

endmodule : thermal_monitor_config_regs

// ---- dv/thermal_monitor_config_regs_sva.sv ----
// Purpose: port-level checks of the configuration register bank
// Assumes: one clock, rst asynchronous and active high
// Notes: shadows the primary and lock bits from the write strobes
`timescale 1ns/1ns
module cfg_chk
   import thermal_cfg_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] reg_ptr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wr_data,
   input wire logic [7:0] reg_rd_data,
   input wire logic local_out_of_limit,
   input wire logic r1_out_of_limit,
   input wire logic r2_out_of_limit,
   input wire logic overtemp_hit,
   input wire logic second_overtemp_hit,
   input wire logic conversions_suspended,
   input wire logic extended_range,
   input wire logic remote_view_second,
   input wire logic overtemp_out_n,
   input wire logic overtemp_oe_n,
   input wire logic shared_pin_out,
   input wire logic shared_pin_oe_n
);
   logic [7:0] shadow, next_shadow;
   logic locked, next_locked, want_low;
   ////////////////////////////////////////////////////////////////////
   // shadow of accepted writes; lock drops only on reset
   always_comb begin
      next_shadow = shadow;
      next_locked = locked;
      if (reg_wr && reg_ptr == PTR_PRIMARY_WR) begin
         next_shadow = locked ? {shadow[7:4], reg_wr_data[3], shadow[2:0]}
            : reg_wr_data & PRIMARY_WR_MASK;
      end
      if (reg_wr && reg_ptr == PTR_LOCK_CFG && reg_wr_data[7]) begin
         next_locked = 1'b1;
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         shadow <= PRIMARY_RESET;
         locked <= 1'b0;
      end else begin
         shadow <= next_shadow;
         locked <= next_locked;
      end
   end
   // level that should pull the shared pin low
   assign want_low = shadow[5] ? second_overtemp_hit : ~shadow[7] &
      (local_out_of_limit | r1_out_of_limit & ~shadow[1]
      | r2_out_of_limit & ~shadow[0]);
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence prim_wr;
      reg_wr && reg_ptr == PTR_PRIMARY_WR;
   endsequence
   sequence frozen_wr;
      prim_wr ##0 locked;
   endsequence
   AST_STANDBY_WR: assert property (prim_wr ##0 !locked |=>
      conversions_suspended == $past(reg_wr_data[6]))
      else $error("standby bit did not follow write");
   AST_VIEW_LOCKED: assert property (frozen_wr |=>
      remote_view_second == $past(reg_wr_data[3])
      && $stable(conversions_suspended))
      else $error("view select or lock wrong");
   AST_RD_PRIMARY: assert property (reg_ptr == PTR_PRIMARY_RD |=>
      reg_rd_data == $past(shadow)) else $error("primary readback wrong");
   AST_RD_LOCK: assert property (reg_ptr == PTR_LOCK_CFG |=>
      reg_rd_data == {$past(locked), 7'h00}) else $error("lock read wrong");
   AST_OT_PIN: assert property (1'b1 |=>
      overtemp_oe_n == !$past(overtemp_hit)) else $error("overtemp pin bad");
   AST_ALERT_MASK: assert property (!shadow[5] && shadow[7] |=>
      shared_pin_oe_n) else $error("masked alert pulled pin low");
   AST_SHARED_PIN: assert property (1'b1 |=>
      shared_pin_oe_n == !$past(want_low)) else $error("shared pin wrong");
   AST_DRIVE_LOW: assert property (overtemp_out_n == 1'b0
      && shared_pin_out == 1'b0) else $error("pin data not low");
   // control outputs update at the same edge as the register itself
   AST_CFG_OUTS: assert property (conversions_suspended == shadow[6]
      && extended_range == shadow[2]
      && remote_view_second == shadow[3])
      else $error("config outputs differ from register");
endmodule : cfg_chk
bind thermal_monitor_config_regs cfg_chk cfg_chk_i (.core_clk, .rst,
   .reg_ptr, .reg_wr, .reg_wr_data, .reg_rd_data, .local_out_of_limit,
   .r1_out_of_limit, .r2_out_of_limit, .overtemp_hit, .second_overtemp_hit,
   .conversions_suspended, .extended_range, .remote_view_second,
   .overtemp_out_n,
   .overtemp_oe_n, .shared_pin_out, .shared_pin_oe_n);

// ---- dv/cfg_host.sv ----
// Purpose: serial engine stand-in on the register port
// Assumes: changes its lines on the falling edge of core_clk
// Notes: rd_take marks the cycle whose read data is valid
`timescale 1ns/1ns
module cfg_host (
   input wire logic core_clk,
   output logic [7:0] reg_ptr,
   output logic reg_wr,
   output logic [7:0] reg_wr_data,
   output logic rd_take
);
   initial begin
      reg_ptr = 8'h00;
      reg_wr = 1'b0;
      reg_wr_data = 8'h00;
      rd_take = 1'b0;
   end
   // one byte; data goes inverse once the strobe drops
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      @(negedge core_clk);
      reg_ptr = p;
      reg_wr = 1'b1;
      reg_wr_data = d;
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_wr_data = ~d;
   endtask : wr
   // pointer held two cycles since read data comes from a flop
   task automatic rd(input logic [7:0] p);
      @(negedge core_clk);
      reg_ptr = p;
      @(negedge core_clk);
      rd_take = 1'b1;
      @(negedge core_clk);
      rd_take = 1'b0;
   endtask : rd
endmodule : cfg_host

// ---- dv/test_thermal_monitor_config_regs.sv ----
// Purpose: self-checking bench for the configuration register bank
// Assumes: host model drives the register port on falling edges
// Notes: expected reads are queued and compared by a monitor
`timescale 1ns/1ns
module test_thermal_monitor_config_regs;
   import thermal_cfg_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic conv_done = 1'b0;
   logic signed [9:0] local_deg = 10'sh000, r1_deg = 10'sh000;
   logic signed [9:0] r2_deg = 10'sh000;
   logic [1:0] r1_quarters = 2'h2, r2_quarters = 2'h3;
   logic local_out_of_limit = 1'b0, r1_out_of_limit = 1'b0;
   logic r2_out_of_limit = 1'b0, overtemp_hit = 1'b0;
   logic second_overtemp_hit = 1'b0;
   logic [7:0] reg_ptr, reg_wr_data, reg_rd_data, cfg;
   logic reg_wr, rd_take, conversions_suspended, extended_range;
   logic remote_view_second, overtemp_out_n, overtemp_oe_n;
   logic shared_pin_out, shared_pin_oe_n;
   logic [7:0] exp_q[$];
   int errors = 0, checks_done = 0, cycles = 0;

   always #4 core_clk = ~core_clk;

   thermal_monitor_config_regs thermal_monitor_config_regs_i (.core_clk,
      .rst, .reg_ptr, .reg_wr, .reg_wr_data, .reg_rd_data, .conv_done,
      .local_deg, .r1_deg, .r1_quarters, .r2_deg, .r2_quarters,
      .local_out_of_limit, .r1_out_of_limit, .r2_out_of_limit,
      .overtemp_hit, .second_overtemp_hit, .conversions_suspended,
      .extended_range, .remote_view_second, .overtemp_out_n, .overtemp_oe_n,
      .shared_pin_out, .shared_pin_oe_n);
   cfg_host cfg_host_i (.core_clk, .reg_ptr, .reg_wr, .reg_wr_data,
      .rd_take);
   ////////////////////////////////////////////////////////////////////
   task automatic check_rd(input logic [7:0] e);
      checks_done++;
      if (reg_rd_data !== e) begin
         errors++;
         $display("mismatch t=%0t got %h exp %h", $time, reg_rd_data, e);
      end
   endtask : check_rd
   task automatic rd_exp(input logic [7:0] p, input logic [7:0] e);
      exp_q.push_back(e);
      cfg_host_i.rd(p);
   endtask : rd_exp
   // one conversion pulse with fresh degrees on all channels
   task automatic conv(input logic signed [9:0] l, a, b);
      @(negedge core_clk);
      local_deg = l;
      r1_deg = a;
      r2_deg = b;
      conv_done = 1'b1;
      @(negedge core_clk);
      conv_done = 1'b0;
   endtask : conv
   task automatic wrap_up();
      $display("errors=%0d checks=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up
   // oldest note is compared when the host flags valid data
   always @(posedge core_clk) begin
      if (rd_take === 1'b1) begin
         check_rd(exp_q.pop_front());
      end
      cycles++;
      if (cycles == 5000) begin
         errors++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h5B7B448A));
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      rd_exp(PTR_PRIMARY_RD, 8'h00);
      rd_exp(PTR_LOCK_CFG, 8'h00);
      rd_exp(PTR_PRIMARY_WR, 8'h00);
      // random settings and limit flags exercise both pins
      for (int i = 0; i < 32; i++) begin
         cfg = 8'($urandom);
         cfg_host_i.wr(PTR_PRIMARY_WR, cfg);
         {local_out_of_limit, r1_out_of_limit, r2_out_of_limit,
            overtemp_hit, second_overtemp_hit} = 5'($urandom);
         rd_exp(PTR_PRIMARY_RD, cfg & PRIMARY_WR_MASK);
      end
      cfg_host_i.wr(PTR_PRIMARY_WR, 8'h00);
      cfg_host_i.wr(PTR_PRIMARY_RD, 8'hFF);
      rd_exp(PTR_PRIMARY_RD, 8'h00);
      conv(10'sd25, 10'sd150, -10'sd55);
      rd_exp(PTR_LOCAL_HI, 8'h19);
      rd_exp(PTR_R1_HI, 8'h7F);
      rd_exp(PTR_R1_LO, 8'h80);
      rd_exp(PTR_R2_HI, 8'h00);
      // range change leaves old result until the next conversion
      cfg_host_i.wr(PTR_PRIMARY_WR, 8'h04);
      rd_exp(PTR_LOCAL_HI, 8'h19);
      conv(10'sd25, 10'sd150, -10'sd55);
      rd_exp(PTR_LOCAL_HI, 8'h59);
      rd_exp(PTR_R1_HI, 8'hD6);
      cfg_host_i.wr(PTR_PRIMARY_WR, 8'h0C);
      rd_exp(PTR_R1_HI, 8'h09);
      rd_exp(PTR_R1_LO, 8'hC0);
      // standby drops conversions but keeps the registers reachable
      cfg_host_i.wr(PTR_PRIMARY_WR, 8'h4C);
      conv(10'sd0, 10'sd0, 10'sd0);
      rd_exp(PTR_LOCAL_HI, 8'h59);
      rd_exp(PTR_R2_LO, 8'hC0);
      cfg_host_i.wr(PTR_LOCK_CFG, 8'hFF);
      rd_exp(PTR_LOCK_CFG, 8'h80);
      cfg_host_i.wr(PTR_LOCK_CFG, 8'h00);
      rd_exp(PTR_LOCK_CFG, 8'h80);
      cfg_host_i.wr(PTR_PRIMARY_WR, 8'h00);
      rd_exp(PTR_PRIMARY_RD, 8'h44);
      cfg_host_i.wr(PTR_PRIMARY_WR, 8'hFF);
      rd_exp(PTR_PRIMARY_RD, 8'h4C);
      // only a fresh reset clears the lock
      rst = 1'b1;
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      rd_exp(PTR_LOCK_CFG, 8'h00);
      rd_exp(PTR_PRIMARY_RD, 8'h00);
      wrap_up();
   end
endmodule : test_thermal_monitor_config_regs
